// File: src/pulse_input_params.svh
// Offsets, field positions, reset values and timing for the mode block.
`ifndef PULSE_INPUT_PARAMS_SVH
`define PULSE_INPUT_PARAMS_SVH
`define OFS_ANALOG_CFG  4'h0
`define OFS_CHA_CFG     4'h1
`define OFS_STATUS      4'h2
`define OFS_COUNT_B0    4'h4
`define OFS_COUNT_B1    4'h5
`define OFS_COUNT_B2    4'h6
`define OFS_COUNT_B3    4'h7
`define RST_ANALOG_CFG  8'h08
`define RST_CHA_CFG     8'h00
`define FLD_TOP_LO      6
`define FLD_MID_LO      3
`define FLD_OPT_LO      0
`define CLK_HZ          25000000
`define DEB_INPUT_US    5000
`define XDEB_UNIT_US    2500
`define PACE_MIN_MS     700
`define PACE_STEP_S     1
`define FREQ_IDLE_S     1
`define FREQ_DECAY_S    100
`endif

// File: src/pulse_input_pkg.sv
// Types shared by the channel A pulse input and analogue mode logic.
package pulse_input_pkg;
	// One octal mode field: top digit, middle digit, option digit.
	typedef struct packed {
		logic [1:0] top;
		logic [2:0] mid;
		logic [2:0] opt;
	} cfg_s;

	// Channel A input modes.
	typedef enum logic [1:0] {
		IN_PLAIN,
		IN_COUNT,
		IN_FREQ,
		IN_RSVD
	} in_mode_e;

	// Analogue output modes.
	typedef enum logic [2:0] {
		AO_DRIVER,
		AO_NORMAL,
		AO_CLKRST,
		AO_BCD,
		AO_RSVD
	} ana_mode_e;

	// Frequency measurement progress.
	typedef enum logic {
		F_WAIT,
		F_RUN
	} freq_state_e;
endpackage : pulse_input_pkg

// File: src/pulse_input_mode_control.sv
// Channel A pulse input, counter, frequency and analogue mode control.
//
// How it works
// - Top digit picks restore or clear of count, with or without linearizing.
// - Linearizing uses table one, after scaling and offset.
// - Middle digit picks plain input, counter, frequency; 3 to 7 reserved.
// - Plain options: none, capture, log, log plus gated interval; 4 reserved.
// - Plain options 5 to 7 equal 1 to 3 with 5 ms debounce.
// - Counter option 0 counts up; option 4 adds debounce.
// - Options 1 and 5 use channel B as direction; B on counts down.
// - Options 2 and 6 count only while channel B is on.
// - Debounce window of 5 ms after each count edge, count input only.
// - Frequency option 0 decays toward zero, zero within 100 seconds.
// - Frequency option 1 forces zero after one second without pulses.
// - Channel B use by channel A overrides channel B's own mode.
// - Analogue modes needing input pins override counter and input modes.
// - Analogue top digit: 0 rejects 60 Hz, 1 rejects 50 Hz.
// - Analogue middle digit: driver pacing, normal, clock/reset, BCD.
// - Driver pacing gap is 700 ms, or 1 to 7 seconds.
// - Clock/reset transfer clock debounce: none, 2.5 to 200 ms.
// - BCD option 0 gives 12-bit outputs, option 1 32-bit outputs.
// - BCD option 1: codes 0 to 9 pick totals; 10 to 15 use source pointer.
`include "pulse_input_params.svh"

module pulse_input_mode_control
	import pulse_input_pkg::*;
#(
	parameter logic [31:0] DEB_CYC =
		32'(`DEB_INPUT_US * (`CLK_HZ / 1000000)),
	parameter logic [31:0] XDEB_UNIT_CYC =
		32'(`XDEB_UNIT_US * (`CLK_HZ / 1000000)),
	parameter logic [31:0] PACE_MIN_CYC =
		32'(`PACE_MIN_MS * (`CLK_HZ / 1000)),
	parameter logic [31:0] PACE_STEP_CYC =
		32'(`PACE_STEP_S * `CLK_HZ),
	parameter logic [31:0] FREQ_IDLE_CYC =
		32'(`FREQ_IDLE_S * `CLK_HZ),
	parameter logic [31:0] FREQ_DECAY_CYC =
		32'(64'(`FREQ_DECAY_S) * 64'(`CLK_HZ))
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Field and controller inputs.
	input  wire logic        pulse_input_a,
	input  wire logic        pulse_input_b,
	input  wire logic        transfer_clock_pin,
	input  wire logic [3:0]  bcd_select,
	// Power-up count restore.
	input  wire logic        power_up_load,
	input  wire logic [31:0] saved_count,
	// Channel A results.
	output logic      [31:0] count_value,
	output logic      [31:0] freq_period,
	output logic             capture_trigger,
	output logic             log_trigger,
	output logic             gated_log_active,
	output logic             lin_enable,
	output logic      [2:0]  lin_table_sel,
	output logic             chan_b_claimed,
	// Analogue output control.
	output logic             mains_50hz,
	output logic             pins_claimed,
	output logic             driver_clock,
	output logic             xfer_clock_pulse,
	output logic             out1_wide,
	output logic             out2_total_en,
	output logic      [3:0]  out2_total_sel,
	output logic             out2_use_pointer
);

	// Rising edge of a sampled level.
	function automatic logic rise(input logic prev, input logic cur);
		rise = cur & ~prev;
	endfunction : rise

	// Gap between driver clock pulses for an option digit.
	function automatic logic [31:0] pace_cycles(input logic [2:0] opt);
		if (opt == 3'h0) begin
			pace_cycles = PACE_MIN_CYC;
		end else begin
			pace_cycles = 32'(opt * PACE_STEP_CYC);
		end
	endfunction : pace_cycles

	// Transfer clock debounce length in 2.5 ms units.
	function automatic logic [31:0] xdeb_cycles(input logic [2:0] opt);
		logic [6:0] mult;
		case (opt)
			3'h0: mult = 7'h00;
			3'h1: mult = 7'h01;
			3'h2: mult = 7'h02;
			3'h3: mult = 7'h04;
			3'h4: mult = 7'h0A;
			3'h5: mult = 7'h14;
			3'h6: mult = 7'h28;
			default: mult = 7'h50;
		endcase
		xdeb_cycles = 32'(mult * XDEB_UNIT_CYC);
	endfunction : xdeb_cycles

	cfg_s        ana_cfg;
	cfg_s        cha_cfg;
	in_mode_e    in_mode;
	ana_mode_e   ana_mode;
	freq_state_e freq_state;
	logic        a_prev;
	logic        x_prev;
	logic        claim;
	logic        a_take;
	logic        deb_sel;
	logic [31:0] deb_cnt;
	logic [31:0] xdeb_cnt;
	logic [31:0] pace_cnt;
	logic [31:0] since;
	logic [31:0] period;
	logic [31:0] next_freq;
	logic [7:0]  status;

	// Input mode decode; 3 to 7 leave the pin a plain level.
	// input mode decode
	always_comb begin
		case (cha_cfg.mid)
			3'h0: in_mode = IN_PLAIN;
			3'h1: in_mode = IN_COUNT;
			3'h2: in_mode = IN_FREQ;
			default: in_mode = IN_RSVD;
		endcase
	end

	// Analogue mode decode.
	// output mode decode
	always_comb begin
		case (ana_cfg.mid)
			3'h0: ana_mode = AO_DRIVER;
			3'h1: ana_mode = AO_NORMAL;
			3'h2: ana_mode = AO_CLKRST;
			3'h3: ana_mode = AO_BCD;
			default: ana_mode = AO_RSVD;
		endcase
	end

	// Transfer modes own the input pins and silence channel A.
	// pin takeover
	assign claim = (ana_mode == AO_CLKRST) | (ana_mode == AO_BCD);

	// Debounce is the high option bit in plain and counter modes.
	// debounce select
	assign deb_sel = cha_cfg.opt[2] & (in_mode != IN_FREQ);

	// An edge is taken unless the pins are claimed or debounce holds it.
	// count edge accept
	assign a_take = rise(a_prev, pulse_input_a) & ~claim &
		(~deb_sel | (deb_cnt == 32'h0));

	// Status byte for software.
	assign status = {chan_b_claimed, pins_claimed, lin_enable,
		mains_50hz, freq_period == 32'h0, pulse_input_a,
		pulse_input_b, freq_state == F_RUN};

	// Configuration writes.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ana_cfg <= `RST_ANALOG_CFG;
			cha_cfg <= `RST_CHA_CFG;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_ANALOG_CFG) begin
				ana_cfg <= reg_wdata;
			end
			if (reg_addr == `OFS_CHA_CFG) begin
				cha_cfg <= reg_wdata;
			end
		end
	end

	// Read data stand for one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`OFS_ANALOG_CFG: reg_rdata <= ana_cfg;
				`OFS_CHA_CFG:    reg_rdata <= cha_cfg;
				`OFS_STATUS:     reg_rdata <= status;
				`OFS_COUNT_B0:   reg_rdata <= count_value[7:0];
				`OFS_COUNT_B1:   reg_rdata <= count_value[15:8];
				`OFS_COUNT_B2:   reg_rdata <= count_value[23:16];
				`OFS_COUNT_B3:   reg_rdata <= count_value[31:24];
				default:         reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Edge history of the sampled inputs.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			a_prev <= 1'b0;
			x_prev <= 1'b0;
		end else begin
			a_prev <= pulse_input_a;
			x_prev <= transfer_clock_pin;
		end
	end

	// Leading-edge debounce window on the channel A input only.
	// debounce window
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			deb_cnt <= 32'h0;
		end else if (a_take && deb_sel) begin
			deb_cnt <= DEB_CYC;
		end else if (deb_cnt != 32'h0) begin
			deb_cnt <= deb_cnt - 32'h1;
		end
	end

	// Plain input side functions; option 4 decodes to none.
	// capture and log
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			capture_trigger  <= 1'b0;
			log_trigger      <= 1'b0;
			gated_log_active <= 1'b0;
		end else begin
			capture_trigger  <= a_take && in_mode == IN_PLAIN &&
				cha_cfg.opt[1:0] == 2'h1;
			log_trigger      <= a_take && in_mode == IN_PLAIN &&
				cha_cfg.opt[1];
			gated_log_active <= ~claim && in_mode == IN_PLAIN &&
				cha_cfg.opt[1:0] == 2'h3 && pulse_input_a;
		end
	end

	// Count update; power-up load restores or clears.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			count_value <= 32'h0;
		end else if (power_up_load) begin
			count_value <= cha_cfg.top[0] ? 32'h0 : saved_count;
		end else if (a_take && in_mode == IN_COUNT) begin
			case (cha_cfg.opt[1:0])
				2'h0: count_value <= count_value + 32'h1;
				2'h1: begin
					if (pulse_input_b) begin
						count_value <= count_value - 32'h1;
					end else begin
						count_value <= count_value + 32'h1;
					end
				end
				2'h2: begin
					if (pulse_input_b) begin
						count_value <= count_value + 32'h1;
					end
				end
				default: count_value <= count_value;
			endcase
		end
	end

	// Frequency period capture between accepted edges.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			freq_state <= F_WAIT;
			since      <= 32'h0;
			period     <= 32'h0;
		end else if (in_mode != IN_FREQ || cha_cfg.opt[2:1] != 2'h0) begin
			freq_state <= F_WAIT;
			since      <= 32'h0;
			period     <= 32'h0;
		end else if (a_take) begin
			case (freq_state)
				F_WAIT: freq_state <= F_RUN;
				F_RUN:  period <= since + 32'h1;
				default: freq_state <= F_WAIT;
			endcase
			since <= 32'h0;
		end else if (since != 32'hFFFFFFFF) begin
			since <= since + 32'h1;
		end
	end

	// Reported period; zero means zero frequency.
	always_comb begin
		next_freq = 32'h0;
		if (freq_state == F_RUN && period != 32'h0) begin
			if (cha_cfg.opt[0]) begin
				if (since < FREQ_IDLE_CYC) begin
					next_freq = period;
				end
			end else if (since < FREQ_DECAY_CYC) begin
				next_freq = (since > period) ? since : period;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			freq_period <= 32'h0;
		end else begin
			freq_period <= next_freq;
		end
	end

	// Linearization and channel B ownership flags.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lin_enable     <= 1'b0;
			lin_table_sel  <= 3'h0;
			chan_b_claimed <= 1'b0;
			pins_claimed   <= 1'b0;
			mains_50hz     <= 1'b0;
		end else begin
			lin_enable     <= cha_cfg.top[1];
			lin_table_sel  <= 3'h0;
			chan_b_claimed <= ~claim && in_mode == IN_COUNT &&
				(cha_cfg.opt[1:0] == 2'h1 || cha_cfg.opt[1:0] == 2'h2);
			pins_claimed   <= claim;
			mains_50hz     <= ana_cfg.top == 2'h1;
		end
	end

	// Driver clock pacing pulses.
	// pacing delay
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pace_cnt     <= 32'h0;
			driver_clock <= 1'b0;
		end else if (ana_mode != AO_DRIVER) begin
			pace_cnt     <= 32'h0;
			driver_clock <= 1'b0;
		end else if (pace_cnt >= pace_cycles(ana_cfg.opt) - 32'h1) begin
			pace_cnt     <= 32'h0;
			driver_clock <= 1'b1;
		end else begin
			pace_cnt     <= pace_cnt + 32'h1;
			driver_clock <= 1'b0;
		end
	end

	// Transfer clock edges with hold-off debounce.
	// clock debounce
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			xdeb_cnt         <= 32'h0;
			xfer_clock_pulse <= 1'b0;
		end else if (ana_mode != AO_CLKRST) begin
			xdeb_cnt         <= 32'h0;
			xfer_clock_pulse <= 1'b0;
		end else if (rise(x_prev, transfer_clock_pin) &&
				xdeb_cnt == 32'h0) begin
			xdeb_cnt         <= xdeb_cycles(ana_cfg.opt);
			xfer_clock_pulse <= 1'b1;
		end else begin
			if (xdeb_cnt != 32'h0) begin
				xdeb_cnt <= xdeb_cnt - 32'h1;
			end
			xfer_clock_pulse <= 1'b0;
		end
	end

	// BCD output routing.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out1_wide        <= 1'b0;
			out2_total_en    <= 1'b0;
			out2_total_sel   <= 4'h0;
			out2_use_pointer <= 1'b0;
		end else begin
			out1_wide        <= ana_mode == AO_BCD && ana_cfg.opt == 3'h1;
			out2_total_en    <= ana_mode == AO_BCD && ana_cfg.opt == 3'h1 &&
				bcd_select <= 4'h9;
			out2_total_sel   <= (bcd_select <= 4'h9) ? bcd_select : 4'h0;
			out2_use_pointer <= ana_mode == AO_BCD && ana_cfg.opt == 3'h1 &&
				bcd_select > 4'h9;
		end
	end
endmodule : pulse_input_mode_control

// File: verification/pulse_source.sv
// Field pulse source model that plays counted pulse trains on one line.
module pulse_source (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Train request: pulse count, high and low widths in cycles.
	input  wire logic       go,
	input  wire logic [7:0] n,
	input  wire logic [7:0] hi,
	input  wire logic [7:0] lo,
	// Pulse line and activity flag.
	output logic            line,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left;
	logic [7:0] t;

	// A low spell precedes every pulse, so each rise is a clean edge.
	always_ff @(posedge core_clk) begin
		if (!rst_b || go) begin
			line <= 1'b0;
			busy <= go;
			left <= n;
			t    <= lo;
		end else if (busy) begin
			if (t > 8'h01) begin
				t <= t - 8'h01;
			end else if (line) begin
				line <= 1'b0;
				t    <= lo;
			end else if (left != 8'h00) begin
				line <= 1'b1;
				t    <= hi;
				left <= left - 8'h01;
			end else begin
				busy <= 1'b0;
			end
		end
	end
endmodule : pulse_source

// File: verification/pulse_input_mode_properties.sv
// Port checks for the channel A and analogue mode control block.
module pulse_input_mode_props
	import pulse_input_pkg::*;
#(
	parameter logic [31:0] PACE_MIN_CYC  = 32'h7,
	parameter logic [31:0] PACE_STEP_CYC = 32'hA
) (
	// Clock, reset and register writes.
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	// Inputs and results watched.
	input wire logic [3:0]  bcd_select,
	input wire logic        power_up_load,
	input wire logic [31:0] count_value,
	input wire logic        capture_trigger,
	input wire logic        lin_enable,
	input wire logic [2:0]  lin_table_sel,
	input wire logic        chan_b_claimed,
	input wire logic        mains_50hz,
	input wire logic        pins_claimed,
	input wire logic        driver_clock,
	input wire logic        out1_wide,
	input wire logic [3:0]  out2_total_sel,
	input wire logic        out2_use_pointer
);
	timeunit 1ns;
	timeprecision 1ns;
	cfg_s        ana;
	cfg_s        cha;
	logic [1:0]  calm;
	logic [31:0] gap;
	logic [31:0] pace;
	logic        gap_ok;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Shadow both mode registers and count quiet cycles since a write.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ana  <= cfg_s'(8'h08);
			cha  <= cfg_s'(8'h00);
			calm <= 2'h0;
		end else if (reg_wr) begin
			ana  <= (reg_addr == 4'h0) ? cfg_s'(reg_wdata) : ana;
			cha  <= (reg_addr == 4'h1) ? cfg_s'(reg_wdata) : cha;
			calm <= 2'h0;
		end else if (calm != 2'h3) begin
			calm <= calm + 2'h1;
		end
	end

	// Cycles between driver clock pulses under one settled setting.
	always_ff @(posedge core_clk) begin
		gap    <= driver_clock ? 32'h1 : gap + 32'h1;
		gap_ok <= rst_b && !reg_wr && (gap_ok || (driver_clock &&
			calm == 2'h3 && ana.mid == 3'h0));
	end
	assign pace = (ana.opt == 3'h0) ? PACE_MIN_CYC :
		PACE_STEP_CYC * 32'(ana.opt);

	a_mains_select: assert property (calm == 2'h3 |->
		mains_50hz == (ana.top == 2'h1)) else $error("mains select wrong");
	a_pins_taken: assert property (calm == 2'h3 |->
		pins_claimed == (ana.mid inside {3'h2, 3'h3}))
		else $error("pin claim wrong");
	a_wide_output: assert property (calm == 2'h3 |->
		out1_wide == (ana.mid == 3'h3 && ana.opt == 3'h1))
		else $error("output 1 width wrong");
	a_lin_on: assert property (calm == 2'h3 |->
		lin_enable == cha.top[1]) else $error("linearize flag wrong");
	a_lin_table: assert property (lin_table_sel == 3'h0)
		else $error("table not first");
	a_b_claim: assert property (calm == 2'h3 && ana.mid < 3'h2 |->
		chan_b_claimed == (cha.mid == 3'h1 && cha.opt[1:0] inside {1, 2}))
		else $error("channel B claim wrong");
	a_bcd_route: assert property (ana.mid == 3'h3 && ana.opt == 3'h1 &&
		$stable(bcd_select) && bcd_select == $past(bcd_select, 2) |->
		out2_use_pointer == (bcd_select > 4'h9) && out2_total_sel ==
		((bcd_select > 4'h9) ? 4'h0 : bcd_select)) else $error("BCD route");
	a_trig_single: assert property (capture_trigger |=>
		!capture_trigger) else $error("capture pulse too long");
	a_count_step: assert property (!$past(power_up_load) &&
		$changed(count_value) |-> count_value - $past(count_value)
		inside {32'h1, 32'hFFFFFFFF}) else $error("count jumped");
	a_count_held: assert property (calm == 2'h3 && ana.mid inside
		{3'h2, 3'h3} && !$past(power_up_load) |-> $stable(count_value))
		else $error("count moved while pins taken");
	a_pace_gap: assert property (driver_clock && gap_ok |->
		gap == pace) else $error("driver pacing wrong");
endmodule : pulse_input_mode_props

bind pulse_input_mode_control pulse_input_mode_props #(
	.PACE_MIN_CYC(PACE_MIN_CYC), .PACE_STEP_CYC(PACE_STEP_CYC)) u_props (
	.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .bcd_select,
	.power_up_load, .count_value, .capture_trigger, .lin_enable,
	.lin_table_sel, .chan_b_claimed, .mains_50hz, .pins_claimed,
	.driver_clock, .out1_wide, .out2_total_sel, .out2_use_pointer);

// File: verification/testbench.sv
// Self-checking bench for the channel A and analogue mode control block.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_b, reg_wr, reg_rd, b_in, pul, go_a, go_c;
	logic [3:0] reg_addr, bcd;
	logic [7:0] reg_wdata, reg_rdata, pn, ph, pl, d;
	logic [31:0] cnt, fp, saved;
	logic a_in, x_in, bs_a, bs_c, cap, lg, drv, xf, lin, mains, pins;
	logic wide, puse, gla, bcl, ten;
	logic [3:0] tsel;
	logic [2:0] lts;
	int failures, n_checks, cap_n, log_n, xf_n, gl_n, c0, l0, l1, k, g;
	// reserved counter options 3 and 7, then reserved input modes 3 and 7 with option zero.
	logic [7:0] rsv [4] = '{8'h0B, 8'h0F, 8'h18, 8'h38};

	pulse_input_mode_control #(.DEB_CYC(32'h8), .XDEB_UNIT_CYC(32'h4),
		.PACE_MIN_CYC(32'h7), .PACE_STEP_CYC(32'hA),
		.FREQ_IDLE_CYC(32'h32), .FREQ_DECAY_CYC(32'hC8))
	u_pulse_input_mode_control (.core_clk, .rst_b, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pulse_input_a(a_in),
		.pulse_input_b(b_in), .transfer_clock_pin(x_in), .bcd_select(bcd),
		.power_up_load(pul), .saved_count(saved), .count_value(cnt),
		.freq_period(fp), .capture_trigger(cap), .log_trigger(lg),
		.gated_log_active(gla), .lin_enable(lin), .lin_table_sel(lts),
		.chan_b_claimed(bcl), .mains_50hz(mains), .pins_claimed(pins),
		.driver_clock(drv), .xfer_clock_pulse(xf), .out1_wide(wide),
		.out2_total_en(ten), .out2_total_sel(tsel),
		.out2_use_pointer(puse));
	pulse_source u_src_a (.core_clk, .rst_b, .go(go_a), .n(pn), .hi(ph),
		.lo(pl), .line(a_in), .busy(bs_a));
	pulse_source u_src_x (.core_clk, .rst_b, .go(go_c), .n(pn), .hi(ph),
		.lo(pl), .line(x_in), .busy(bs_c));

	// Clock at 25 MHz.
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Tally trigger pulses seen at the outputs.
	always @(posedge core_clk) begin
		cap_n <= cap_n + int'(cap === 1'b1);
		log_n <= log_n + int'(lg === 1'b1);
		xf_n  <= xf_n + int'(xf === 1'b1);
		gl_n  <= gl_n + int'(gla === 1'b1);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic limit(input int n);
		if (n >= 3000) begin
			failures++;
			$display("BAD t=%0t wait ran out", $time);
			tally_and_finish();
		end
	endtask : limit

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		v = reg_rdata;
		@(posedge core_clk);
	endtask : rd

	// Play a train on line A or the transfer clock and wait for its end.
	task automatic train(input logic c, input logic [7:0] n, h, l);
		pn <= n;
		ph <= h;
		pl <= l;
		go_a <= !c;
		go_c <= c;
		@(posedge core_clk);
		go_a <= 1'b0;
		go_c <= 1'b0;
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while ((bs_a || bs_c) && k < 3000);
		limit(k);
		repeat (4) @(posedge core_clk);
	endtask : train

	task automatic power_up(input logic [7:0] cfg, input logic [31:0] exp);
		wr(4'h1, cfg);
		saved <= 32'h0000_1234;
		pul <= 1'b1;
		@(posedge core_clk);
		pul <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(cnt, exp);
		chk(lin, cfg[7]);
		chk(lts, 0);
	endtask : power_up

	initial begin
		{rst_b, reg_wr, reg_rd, b_in, pul, go_a, go_c} = '0;
		{reg_addr, bcd, reg_wdata, pn, ph, pl, saved} = '0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(4'h0, d);
		chk(d, 8'h08);
		rd(4'h1, d);
		chk(d, 8'h00);
		wr(4'h3, 8'hFF);
		rd(4'h3, d);
		chk(d, 8'h00);
		$display("register test done");
		wr(4'h1, 8'h08);
		train(0, 4, 1, 1);
		chk(cnt, 4);
		wr(4'h1, 8'h0C);
		train(0, 4, 1, 1);
		chk(cnt, 5);
		train(0, 3, 5, 5);
		chk(cnt, 8);
		wr(4'h1, 8'h09);
		b_in <= 1'b1;
		chk(bcl, 1);
		train(0, 3, 1, 1);
		chk(cnt, 5);
		wr(4'h1, 8'h0D);
		train(0, 4, 1, 1);
		chk(cnt, 4);
		wr(4'h1, 8'h0E);
		train(0, 4, 1, 1);
		chk(cnt, 5);
		wr(4'h1, 8'h0A);
		b_in <= 1'b0;
		train(0, 3, 1, 1);
		chk(cnt, 5);
		for (int i = 0; i < 4; i++) begin
			wr(4'h1, rsv[i]);
			train(0, 2, 1, 1);
			chk(cnt, 5);
		end
		wr(4'h1, 8'h08);
		wr(4'h0, 8'h10);
		train(0, 3, 1, 1);
		chk(cnt, 5);
		rd(4'h4, d);
		chk(d, 8'h05);
		wr(4'h0, 8'h20);
		chk(pins, 0);
		$display("counter test done");
		for (int o = 0; o < 8; o++) begin
			wr(4'h1, 8'(o));
			c0 = cap_n;
			l0 = log_n;
			l1 = gl_n;
			train(0, 4, 1, 1);
			g = o[2] ? 1 : 4;
			chk(cap_n - c0, (o[1:0] == 1) ? g : 0);
			chk(log_n - l0, (o[1:0] > 1) ? g : 0);
			chk(gl_n - l1, (o[1:0] == 3) ? 4 : 0);
		end
		wr(4'h1, 8'h11);
		train(0, 3, 5, 5);
		chk(fp, 10);
		repeat (60) @(posedge core_clk);
		chk(fp, 0);
		wr(4'h1, 8'h10);
		train(0, 3, 5, 5);
		repeat (100) @(posedge core_clk);
		chk(fp > 100, 1);
		repeat (150) @(posedge core_clk);
		chk(fp, 0);
		$display("input and frequency test done");
		for (int o = 0; o < 8; o++) begin
			wr(4'h0, 8'(o));
			k = 0;
			do begin
				@(negedge core_clk);
				k++;
			end while (!drv && k < 3000);
			limit(k);
			g = 0;
			do begin
				@(negedge core_clk);
				g++;
			end while (!drv && g < 3000);
			limit(g);
			chk(g, (o == 0) ? 7 : o * 10);
			@(posedge core_clk);
		end
		for (int o = 0; o < 3; o += 2) begin
			wr(4'h0, 8'h10 + 8'(o));
			c0 = xf_n;
			train(1, 4, 1, 1);
			chk(xf_n - c0, (o == 0) ? 4 : 1);
		end
		wr(4'h0, 8'h59);
		chk(wide, 1);
		chk(mains, 1);
		for (int b = 0; b < 16; b++) begin
			bcd <= 4'(b);
			repeat (3) @(posedge core_clk);
			chk(tsel, (b > 9) ? 0 : b);
			chk(puse, b > 9);
			chk(ten, b <= 9);
		end
		wr(4'h0, 8'h18);
		chk(wide, 0);
		chk(pins, 1);
		$display("analogue test done");
		wr(4'h0, 8'h08);
		power_up(8'h48, 0);
		power_up(8'h88, 32'h1234);
		power_up(8'hC8, 0);
		$display("power-up test done");
		tally_and_finish();
	end
endmodule : testbench
